// [src/channel_initial_status_switch.sv]
// initial-status responder and dual host switch allegiance logic
// assumes synchronous host tags; control program bits arrive as plain ports
`timescale 1ns/1ps
`include "cis_cfg.svh"
module channel_initial_status_switch
    import cis_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       resetn,
    input  wire cis_sel_t   selA,
    input  wire cis_sel_t   selB,
    input  wire logic [1:0] ifEnable,
    input  wire logic [7:0] nativeAddrA,
    input  wire logic [7:0] nativeAddrB,
    input  wire cis_irq_t   irqPending,
    input  wire logic       cpIntReset,
    input  wire logic       cpStatusLoad,
    input  wire logic [7:0] cpStatus,
    input  wire logic       escTestLoaded,
    input  wire logic [7:0] escTestAddr,
    input  wire logic [7:0] escTestStatus,
    input  wire logic       escEndPending,
    input  wire logic       devEndNoChain,
    input  wire logic       cpNeutral,
    input  wire logic [1:0] disableReq,
    input  wire logic       stsAccept,
    input  wire logic       stsStack,
    output logic      [1:0] selBypass,
    output logic      [1:0] selHold,
    output logic            stsValid,
    output logic      [7:0] stsByte,
    output logic      [1:0] stsIf,
    output logic            isIntReq,
    output logic      [7:0] selStatus,
    output logic     [15:0] addrCmd,
    output logic      [7:0] nativeStatus,
    output logic            switched,
    output logic            allegIdx
);

    function automatic cis_kind_t cmdKind(input logic [7:0] cmd);
        if (cmd == `CIS_CMD_TIO)
            return CIS_K_TIO;
        else if (cmd == `CIS_CMD_NOP)
            return CIS_K_NOP;
        else if (cmd[1:0] == 2'b11)
            return CIS_K_CTL;
        else
            return CIS_K_STD;
    endfunction

    cis_state_t state_ff,   nxt_state;
    logic [7:0] stsByte_ff, nxt_stsByte;
    logic       stsIdx_ff,  nxt_stsIdx;
    logic       isDe_ff,    nxt_isDe;
    logic       alg_ff,     nxt_alg;
    logic       owe_ff,     nxt_owe;
    logic       natTio_ff,  nxt_natTio;
    logic       fromNat_ff, nxt_fromNat;
    logic       uc_ff,      nxt_uc;
    logic [15:0] curAc_ff,  nxt_curAc;
    logic       allegOn_ff, nxt_allegOn;
    logic       allegIdx_ff, nxt_allegIdx;
    logic [1:0] owed_ff,    nxt_owed;
    logic       isInt_ff,   nxt_isInt;
    logic       stk_ff,     nxt_stk;
    logic       boc_ff,     nxt_boc;
    logic [15:0] addrCmd_ff, nxt_addrCmd;
    logic [7:0] natSts_ff,  nxt_natSts;
    logic       last_ff,    nxt_last;

    logic       partitioned;
    logic [1:0] isNat;
    logic [1:0] usable;
    logic [1:0] cand;
    logic       win;
    cis_sel_t   ws;
    cis_kind_t  wk;
    logic       cuBusy;
    logic       deGo;
    logic       take;
    logic       done;
    logic       stackOk;
    logic [7:0] pByte;
    logic       pAlg;
    logic       pOwe;
    logic       pNatTio;
    logic       pFromNat;

    assign partitioned = ^ifEnable;
    assign isNat[0] = selA.addr == nativeAddrA;
    assign isNat[1] = selB.addr == nativeAddrB;
    // emulation addresses only while partitioned
    assign usable = ifEnable & (isNat | {2{partitioned}});
    assign cand = {selB.req, selA.req} & usable;
    // alternate winner when both select together
    assign win = cand[1] & (~cand[0] | ~last_ff);
    assign ws = win ? selB : selA;
    assign wk = cmdKind(ws.cmd);
    assign cuBusy = isInt_ff | (|irqPending);
    assign deGo = ~allegOn_ff & (|owed_ff) & ~cuBusy;
    assign take = (state_ff == CIS_IDLE) & ~deGo & (|cand);
    assign done = (state_ff == CIS_PRESENT) & (stsAccept | stsStack);
    assign stackOk = stsStack & ((stsByte_ff != `CIS_ST_ZERO) | natTio_ff);

    // initial status for the winning selection
    always_comb
    begin
        pByte = `CIS_ST_ZERO;
        pAlg = 1'b0;
        pOwe = 1'b0;
        pNatTio = 1'b0;
        pFromNat = 1'b0;
        if (allegOn_ff & (allegIdx_ff != win))
        begin
            pByte = `CIS_ST_BUSY;
            pOwe = 1'b1;
        end
        else if (isNat[win])
        begin
            pNatTio = wk == CIS_K_TIO;
            if (!ws.parityOk)
                pByte = `CIS_ST_UC;
            else if (cuBusy)
                pByte = `CIS_ST_CUBUSY;
            else if (natSts_ff != `CIS_ST_ZERO)
            begin
                pFromNat = 1'b1;
                pByte = natSts_ff | ((wk == CIS_K_TIO) ? `CIS_ST_ZERO : `CIS_ST_BUSY);
            end
            else if (allegOn_ff)
                pByte = `CIS_ST_BUSY;
            else
            begin
                case (wk)
                    CIS_K_TIO: pByte = `CIS_ST_ZERO;
                    CIS_K_NOP: pByte = `CIS_ST_CEDE;
                    CIS_K_CTL: pByte = `CIS_ST_CE;
                    default:
                    begin
                        pByte = `CIS_ST_ZERO;
                        pAlg = 1'b1;
                    end
                endcase
            end
        end
        else if (!ws.parityOk)
            pByte = `CIS_ST_UC;
        else if (wk == CIS_K_TIO)
        begin
            if (isInt_ff | ~escTestLoaded | (escTestAddr != ws.addr) | escEndPending)
                pByte = `CIS_ST_CUBUSY;
            else
                pByte = escTestStatus;
        end
        else if (cuBusy)
            pByte = `CIS_ST_CUBUSY;
        else if (wk == CIS_K_NOP)
            pByte = `CIS_ST_CEDE;
        else
        begin
            pByte = `CIS_ST_ZERO;
            pAlg = 1'b1;
        end
    end

    always_comb
    begin
        nxt_state = state_ff;
        nxt_stsByte = stsByte_ff;
        nxt_stsIdx = stsIdx_ff;
        nxt_isDe = isDe_ff;
        nxt_alg = alg_ff;
        nxt_owe = owe_ff;
        nxt_natTio = natTio_ff;
        nxt_fromNat = fromNat_ff;
        nxt_uc = uc_ff;
        nxt_curAc = curAc_ff;
        nxt_allegOn = allegOn_ff;
        nxt_allegIdx = allegIdx_ff;
        nxt_owed = owed_ff & ~disableReq; // disable cancels owed device end
        nxt_isInt = isInt_ff & ~cpIntReset;
        nxt_stk = stk_ff & ~cpIntReset;
        nxt_boc = boc_ff & ~cpIntReset;
        nxt_addrCmd = addrCmd_ff;
        nxt_natSts = cpStatusLoad ? cpStatus : natSts_ff;
        nxt_last = last_ff;
        if (devEndNoChain | cpNeutral)
            nxt_allegOn = 1'b0;
        if ((state_ff == CIS_IDLE) & deGo)
        begin
            nxt_state = CIS_PRESENT;
            nxt_stsByte = `CIS_ST_DE;
            nxt_stsIdx = ~owed_ff[0];
            nxt_isDe = 1'b1;
            nxt_alg = 1'b0;
            nxt_owe = 1'b0;
            nxt_natTio = 1'b0;
            nxt_fromNat = 1'b0;
            nxt_uc = 1'b0;
        end
        else if (take)
        begin
            nxt_state = CIS_PRESENT;
            nxt_stsByte = pByte;
            nxt_stsIdx = win;
            nxt_isDe = 1'b0;
            nxt_alg = pAlg;
            nxt_owe = pOwe;
            nxt_natTio = pNatTio;
            nxt_fromNat = pFromNat;
            nxt_uc = pByte == `CIS_ST_UC;
            nxt_curAc = {ws.addr, ws.cmd};
            nxt_last = win;
        end
        if (done)
        begin
            nxt_state = CIS_IDLE;
            if (isDe_ff)
                nxt_owed[stsIdx_ff] = 1'b0;
            else if (owe_ff)
                nxt_owed[stsIdx_ff] = 1'b1;
            else if (stackOk)
            begin
                nxt_isInt = 1'b1;
                nxt_stk = 1'b1;
                nxt_boc = uc_ff | boc_ff;
                nxt_addrCmd = curAc_ff;
                if (natTio_ff)
                    nxt_natSts = stsByte_ff;
            end
            else
            begin
                if (fromNat_ff)
                    nxt_natSts = `CIS_ST_ZERO;
                if (alg_ff | (stsByte_ff == `CIS_ST_CE))
                begin
                    nxt_isInt = 1'b1;
                    nxt_addrCmd = curAc_ff;
                end
                if (alg_ff)
                begin
                    nxt_allegOn = 1'b1;
                    nxt_allegIdx = stsIdx_ff;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            state_ff <= CIS_IDLE;
            stsByte_ff <= `CIS_ST_ZERO;
            stsIdx_ff <= 1'b0;
            isDe_ff <= 1'b0;
            alg_ff <= 1'b0;
            owe_ff <= 1'b0;
            natTio_ff <= 1'b0;
            fromNat_ff <= 1'b0;
            uc_ff <= 1'b0;
            curAc_ff <= 16'h0000;
            allegOn_ff <= 1'b0;
            allegIdx_ff <= 1'b0;
            owed_ff <= 2'h0;
            isInt_ff <= 1'b0;
            stk_ff <= 1'b0;
            boc_ff <= 1'b0;
            addrCmd_ff <= 16'h0000;
            natSts_ff <= `CIS_ST_ZERO;
            last_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            stsByte_ff <= nxt_stsByte;
            stsIdx_ff <= nxt_stsIdx;
            isDe_ff <= nxt_isDe;
            alg_ff <= nxt_alg;
            owe_ff <= nxt_owe;
            natTio_ff <= nxt_natTio;
            fromNat_ff <= nxt_fromNat;
            uc_ff <= nxt_uc;
            curAc_ff <= nxt_curAc;
            allegOn_ff <= nxt_allegOn;
            allegIdx_ff <= nxt_allegIdx;
            owed_ff <= nxt_owed;
            isInt_ff <= nxt_isInt;
            stk_ff <= nxt_stk;
            boc_ff <= nxt_boc;
            addrCmd_ff <= nxt_addrCmd;
            natSts_ff <= nxt_natSts;
            last_ff <= nxt_last;
        end
    end

    assign selBypass = ~usable;
    // a usable selection that is not being answered now waits
    assign selHold = cand & ~((state_ff == CIS_PRESENT) ? {stsIdx_ff, ~stsIdx_ff} : 2'b00);
    assign stsValid = state_ff == CIS_PRESENT;
    assign stsByte = stsByte_ff;
    assign stsIf = stsValid ? {stsIdx_ff, ~stsIdx_ff} : 2'b00;
    assign isIntReq = isInt_ff;
    assign selStatus = {2'b00, stk_ff, 1'b0, boc_ff, 3'b000};
    assign addrCmd = addrCmd_ff;
    assign nativeStatus = natSts_ff;
    assign switched = allegOn_ff;
    assign allegIdx = allegIdx_ff;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    ctl_channel_end_a: assert property (take & isNat[win] & ws.parityOk & ~(allegOn_ff) & ~cuBusy &
        (natSts_ff == 8'h00) & (wk == CIS_K_CTL) |=> stsValid & (stsByte == 8'h08))
        else $error("native control command not answered with channel end");
    nop_cede_a: assert property (take & ws.parityOk & ~allegOn_ff & ~cuBusy & (natSts_ff == 8'h00) &
        (wk == CIS_K_NOP) |=> stsByte == 8'h0C)
        else $error("no-op not answered with channel end and device end");
    cu_busy_a: assert property (take & isNat[win] & ws.parityOk & ~allegOn_ff & cuBusy |=>
        stsByte == 8'h70)
        else $error("pending interrupt did not give control unit busy");
    esc_parity_a: assert property (take & ~isNat[win] & ~allegOn_ff & ~ws.parityOk |=> stsByte == 8'h02)
        else $error("emulation bad parity not answered with unit check");
    stack_flags_a: assert property (done & stackOk & ~isDe_ff & ~owe_ff |=> isIntReq & selStatus[5])
        else $error("stacked status did not raise interrupt and flag");
    zero_stack_a: assert property (done & stsStack & (stsByte == 8'h00) & ~natTio_ff |=>
        $stable(selStatus[5]) | ~selStatus[5])
        else $error("zero status stacked outside native test");
    other_busy_a: assert property (take & allegOn_ff & (allegIdx_ff != win) |=> stsByte == 8'h10 ##0
        stsIf[~allegIdx_ff])
        else $error("other interface not refused with busy");
    bypass_disabled_a: assert property (~ifEnable[0] |-> selBypass[0] & ~stsIf[0] | isDe_ff)
        else $error("disabled interface not bypassed");
    one_side_a: assert property (stsIf != 2'b11)
        else $error("status driven to both interfaces");
    owed_de_a: assert property ((state_ff == CIS_IDLE) & deGo |=> stsValid & (stsByte == 8'h04))
        else $error("owed device end not presented");

endmodule

// [src/cis_cfg.svh]
// status codes, command codes and flag positions of the initial-status responder
// assumes inclusion by bare name from the design file
`ifndef CIS_CFG_SVH
`define CIS_CFG_SVH
`define CIS_ST_ZERO   8'h00
`define CIS_ST_UC     8'h02
`define CIS_ST_DE     8'h04
`define CIS_ST_CE     8'h08
`define CIS_ST_CEDE   8'h0C
`define CIS_ST_BUSY   8'h10
`define CIS_ST_CUBUSY 8'h70
`define CIS_CMD_TIO   8'h00
`define CIS_CMD_NOP   8'h03
`define CIS_SS_BOC    3
`define CIS_SS_STK    5
`define CIS_RST_ADDR  8'h00
`endif

// [src/cis_pkg.sv]
// types of the initial-status responder with dual host switch
// assumes nothing beyond a SystemVerilog compiler
package cis_pkg;
    typedef enum logic {CIS_IDLE, CIS_PRESENT} cis_state_t;
    typedef enum logic [1:0] {CIS_K_STD, CIS_K_CTL, CIS_K_NOP, CIS_K_TIO} cis_kind_t;
    typedef struct packed {
        logic       req;
        logic [7:0] addr;
        logic [7:0] cmd;
        logic       parityOk;
    } cis_sel_t;
    typedef struct packed {
        logic sysReset;
        logic selReset;
        logic progReq;
    } cis_irq_t;
endpackage

// [tb/cis_host_model.sv]
// host channel model: selects over A or B, then accepts or stacks the status
// assumes the responder presents status the cycle after it takes a request
`timescale 1ns/1ps
module cis_host_model
    import cis_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       stsValid,
    input  wire logic [7:0] stsByte,
    input  wire logic [1:0] stsIf,
    output cis_sel_t        selA,
    output cis_sel_t        selB,
    output logic            stsAccept,
    output logic            stsStack
);
    initial
    begin
        selA = '{req: 1'b0, addr: 8'h00, cmd: 8'h00, parityOk: 1'b1};
        selB = '{req: 1'b0, addr: 8'h00, cmd: 8'h00, parityOk: 1'b1};
        stsAccept = 1'b0;
        stsStack = 1'b0;
    end

    // doReq low: only wait for a status the device offers by itself
    task automatic run(input logic doReq, input logic side, input logic [7:0] a, input logic [7:0] c,
                       input logic par, input logic stk, output logic [7:0] st, output logic [1:0] si,
                       output logic ok);
        int n;
        cis_sel_t s;
        cis_sel_t r;
        s = '{req: doReq, addr: a, cmd: c, parityOk: par};
        r = '{req: 1'b0, addr: ~a, cmd: ~c, parityOk: ~par};
        ok = 1'b0;
        st = 8'h00;
        si = 2'b00;
        n = 0;
        if (side)
            selB <= s;
        else
            selA <= s;
        while (!ok && n < 20)
        begin
            @(posedge clock);
            n++;
            if (stsValid === 1'b1)
            begin
                st = stsByte;
                si = stsIf;
                ok = 1'b1;
                stsAccept <= !stk;
                stsStack <= stk;
            end
        end
        @(posedge clock);
        stsAccept <= 1'b0;
        stsStack <= 1'b0;
        // released lines drop req and show the inverse address, command and parity
        if (side)
            selB <= r;
        else
            selA <= r;
        @(posedge clock);
    endtask
endmodule

// [tb/test_channel_initial_status_switch.sv]
// self-checking bench of the initial-status responder and host switch
// assumes cis_host_model plays both host channels
`timescale 1ns/1ps
module test_channel_initial_status_switch
    import cis_pkg::*;
;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] cmd;
        logic       par;
        logic       ld;
        logic [7:0] exp;
    } cis_row_t;
    localparam cis_row_t ROWS [10] = '{
        '{8'h10, 8'h03, 1'b1, 1'b0, 8'h0C}, '{8'h10, 8'h07, 1'b1, 1'b0, 8'h08},
        '{8'h10, 8'h00, 1'b1, 1'b0, 8'h00}, '{8'h10, 8'h81, 1'b0, 1'b0, 8'h02},
        '{8'h40, 8'h01, 1'b1, 1'b0, 8'h00}, '{8'h40, 8'h03, 1'b1, 1'b0, 8'h0C},
        '{8'h40, 8'h01, 1'b0, 1'b0, 8'h02}, '{8'h40, 8'h00, 1'b1, 1'b0, 8'h70},
        '{8'h40, 8'h00, 1'b1, 1'b1, 8'h0E}, '{8'h41, 8'h00, 1'b1, 1'b1, 8'h70}};
    logic clock = 1'b0;
    logic resetn = 1'b0;
    cis_sel_t selA, selB;
    logic [1:0] ifEnable = 2'b01;
    cis_irq_t irqPending = 3'b000;
    logic cpIntReset = 1'b0, cpStatusLoad = 1'b0, escTestLoaded = 1'b0, escEndPending = 1'b0;
    logic devEndNoChain = 1'b0, cpNeutral = 1'b0, stsAccept, stsStack, stsValid, isIntReq, switched, allegIdx;
    logic [7:0] cpStatus = 8'h00, stsByte, selStatus, nativeStatus, st;
    logic [1:0] disableReq = 2'b00, selBypass, selHold, stsIf, si;
    logic [15:0] addrCmd;
    logic ok;
    logic sawHold = 1'b0;
    int nErrors = 0, nCompared = 0, cycles = 0;

    always #5 clock = ~clock;

    // remembers a B selection held while A is being answered
    always @(posedge clock)
    begin
        if (stsIf == 2'b01 && selHold[1])
            sawHold <= 1'b1;
    end

    channel_initial_status_switch u_channel_initial_status_switch (
        .clock(clock), .resetn(resetn), .selA(selA), .selB(selB), .ifEnable(ifEnable),
        .nativeAddrA(8'h10), .nativeAddrB(8'h20), .irqPending(irqPending), .cpIntReset(cpIntReset),
        .cpStatusLoad(cpStatusLoad), .cpStatus(cpStatus), .escTestLoaded(escTestLoaded),
        .escTestAddr(8'h40), .escTestStatus(8'h0E), .escEndPending(escEndPending),
        .devEndNoChain(devEndNoChain), .cpNeutral(cpNeutral), .disableReq(disableReq),
        .stsAccept(stsAccept), .stsStack(stsStack), .selBypass(selBypass), .selHold(selHold),
        .stsValid(stsValid), .stsByte(stsByte), .stsIf(stsIf), .isIntReq(isIntReq),
        .selStatus(selStatus), .addrCmd(addrCmd), .nativeStatus(nativeStatus),
        .switched(switched), .allegIdx(allegIdx));

    cis_host_model u_cis_host_model (
        .clock(clock), .stsValid(stsValid), .stsByte(stsByte), .stsIf(stsIf), .selA(selA),
        .selB(selB), .stsAccept(stsAccept), .stsStack(stsStack));

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        nCompared++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
            nErrors++;
        end
    endtask

    task automatic go(input logic d, input logic s, input logic [7:0] a, input logic [7:0] c,
                      input logic p, input logic k);
        u_cis_host_model.run(d, s, a, c, p, k, st, si, ok);
    endtask

    // one-cycle program pulses: interrupt reset and unchained device end
    task automatic pulse(input logic ir, input logic de);
        cpIntReset <= ir;
        devEndNoChain <= de;
        @(posedge clock);
        cpIntReset <= 1'b0;
        devEndNoChain <= 1'b0;
        @(posedge clock);
    endtask

    task automatic load(input logic [7:0] v);
        cpStatusLoad <= 1'b1;
        cpStatus <= v;
        @(posedge clock);
        cpStatusLoad <= 1'b0;
        @(posedge clock);
    endtask

    task automatic tally_and_finish();
        if (nErrors == 0 && nCompared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            nErrors++;
            tally_and_finish();
        end
    end

    initial
    begin
        repeat (6) @(posedge clock);
        chk("reset outputs", 16'h0000, {stsValid, isIntReq, switched, selStatus, 5'h00});
        resetn <= 1'b1;
        @(posedge clock);
        for (int i = 0; i < 10; i++)
        begin
            escTestLoaded <= ROWS[i].ld;
            go(1'b1, 1'b0, ROWS[i].addr, ROWS[i].cmd, ROWS[i].par, 1'b0);
            chk("row status", {8'h00, ROWS[i].exp}, {8'h00, st});
            pulse(1'b1, 1'b1);
        end
        escEndPending <= 1'b1;
        go(1'b1, 1'b0, 8'h40, 8'h00, 1'b1, 1'b0);
        chk("emul end busy", 16'h0070, {8'h00, st});
        escEndPending <= 1'b0;
        escTestLoaded <= 1'b0;
        pulse(1'b1, 1'b1);
        for (int i = 0; i < 3; i++)
        begin
            irqPending <= 3'b001 << i;
            go(1'b1, 1'b0, 8'h10, 8'h03, 1'b1, 1'b0);
            chk("cu busy", 16'h0070, {8'h00, st});
            irqPending <= 3'b000;
            pulse(1'b1, 1'b0);
        end
        go(1'b1, 1'b0, 8'h10, 8'h03, 1'b1, 1'b1);
        chk("stack flags", 16'h2001, {selStatus, 7'h00, isIntReq});
        chk("stack addr cmd", 16'h1003, addrCmd);
        pulse(1'b1, 1'b0);
        go(1'b1, 1'b0, 8'h10, 8'h81, 1'b0, 1'b1);
        chk("stack parity", 16'h2802, {selStatus, st});
        pulse(1'b1, 1'b0);
        go(1'b1, 1'b0, 8'h10, 8'h00, 1'b1, 1'b1);
        chk("stack zero test", 16'h2000, {selStatus, st});
        pulse(1'b1, 1'b0);
        go(1'b1, 1'b0, 8'h40, 8'h01, 1'b1, 1'b1);
        chk("zero not stacked", 16'h0000, {selStatus, st});
        pulse(1'b1, 1'b1);
        escTestLoaded <= 1'b1;
        go(1'b1, 1'b0, 8'h40, 8'h00, 1'b1, 1'b1);
        chk("stack emul test", 16'h200E, {selStatus, st});
        chk("emul addr cmd", 16'h4000, addrCmd);
        go(1'b1, 1'b0, 8'h40, 8'h00, 1'b1, 1'b0);
        chk("emul int busy", 16'h0070, {8'h00, st});
        escTestLoaded <= 1'b0;
        // stacked emulation test status handled as a final status stack
        pulse(1'b1, 1'b0);
        load(8'h0C);
        chk("native reg", 16'h000C, {8'h00, nativeStatus});
        go(1'b1, 1'b0, 8'h10, 8'h00, 1'b1, 1'b1);
        chk("stack pending test", 16'h0C0C, {st, nativeStatus});
        // no reload: the saved status waits for the next test
        pulse(1'b1, 1'b0);
        go(1'b1, 1'b0, 8'h10, 8'h00, 1'b1, 1'b0);
        chk("pending test", 16'h0C00, {st, nativeStatus});
        pulse(1'b1, 1'b1);
        load(8'h0C);
        go(1'b1, 1'b0, 8'h10, 8'h01, 1'b1, 1'b0);
        chk("pending busy", 16'h001C, {8'h00, st});
        pulse(1'b1, 1'b1);
        go(1'b1, 1'b1, 8'h20, 8'h03, 1'b1, 1'b0);
        chk("disabled bypass", 16'h0002, {7'h00, ok, 6'h00, selBypass});
        ifEnable <= 2'b11;
        go(1'b1, 1'b0, 8'h40, 8'h01, 1'b1, 1'b0);
        chk("emul unpartitioned", 16'h0000, {15'h0000, ok});
        go(1'b1, 1'b0, 8'h10, 8'h01, 1'b1, 1'b0);
        chk("allegiance A", 16'h0002, {st, 6'h00, switched, allegIdx});
        pulse(1'b1, 1'b0);
        go(1'b1, 1'b0, 8'h10, 8'h01, 1'b1, 1'b0);
        chk("own active busy", 16'h0010, {8'h00, st});
        pulse(1'b1, 1'b0);
        go(1'b1, 1'b1, 8'h20, 8'h01, 1'b1, 1'b0);
        chk("other side busy", 16'h1002, {st, 6'h00, si});
        pulse(1'b1, 1'b0);
        pulse(1'b0, 1'b1);
        go(1'b0, 1'b1, 8'h20, 8'h01, 1'b1, 1'b0);
        chk("owed device end", 16'h0402, {st, 6'h00, si});
        chk("neutral again", 16'h0000, {15'h0000, switched});
        u_cis_host_model.selB <= '{req: 1'b1, addr: 8'h20, cmd: 8'h03, parityOk: 1'b1};
        go(1'b1, 1'b0, 8'h10, 8'h03, 1'b1, 1'b0);
        chk("A wins", 16'h0C01, {st, 6'h00, si});
        go(1'b0, 1'b1, 8'h20, 8'h03, 1'b1, 1'b0);
        chk("B held then served", 16'h0C06, {st, 5'h00, sawHold, si});
        go(1'b1, 1'b0, 8'h10, 8'h01, 1'b1, 1'b0);
        pulse(1'b1, 1'b0);
        go(1'b1, 1'b1, 8'h20, 8'h01, 1'b1, 1'b0);
        chk("busy before disable", 16'h1002, {st, 6'h00, si});
        disableReq <= 2'b10;
        cpNeutral <= 1'b1;
        pulse(1'b1, 1'b0);
        disableReq <= 2'b00;
        cpNeutral <= 1'b0;
        go(1'b0, 1'b1, 8'h20, 8'h01, 1'b1, 1'b0);
        chk("disable drops de", 16'h0000, {14'h0000, ok, switched});
        load(8'h0C);
        resetn <= 1'b0;
        @(posedge clock);
        @(posedge clock);
        chk("mid reset", 16'h0000, {nativeStatus, 6'h00, stsValid, switched});
        resetn <= 1'b1;
        @(posedge clock);
        go(1'b1, 1'b0, 8'h10, 8'h03, 1'b1, 1'b0);
        chk("after reset", 16'h0C01, {st, 6'h00, si});
        ifEnable <= 2'b10;
        go(1'b1, 1'b0, 8'h10, 8'h03, 1'b1, 1'b0);
        chk("disabled A", 16'h0001, {7'h00, ok, 6'h00, selBypass});
        tally_and_finish();
    end
endmodule
